// [test_vmc_regs.sv]
// test_vmc_regs: self-checking bench for the capability register bank.
// assumes: vmc_ee_model stands in for the EEPROM controller.
`timescale 1ns/10ps

module test_vmc_regs;
  import vmc_pkg::*;
  logic clk_sys = '0, rstn = '0, up = '0, al_valid = '0, link_down = '0, rd_d = '0;
  logic [1:0] al_bits = '0;
  logic [3:0] lat = '0;
  vmc_bus_s bus = '0;
  vmc_ee_req_s ee_req;
  vmc_ee_rsp_s ee_rsp;
  logic [DW-1:0] rdata, msi_addr_hi, d, av;
  logic [31:0] lfsr = 32'h8F4B;
  logic [15:0] msi_data;
  logic role_en, dn_role, hr_fwd, irq;
  logic [5:0] adr [2] = '{6'h00, 6'h3F};
  logic [DW-1:0] exp_q [$];
  string nm_q [$];
  int error_cnt = 0, n_tests = 0, cyc = 0;

  vmc_regs u_vmc_regs (.clk_sys(clk_sys), .rstn(rstn), .is_upstream(up), .bus(bus),
    .rdata(rdata), .ee_req(ee_req), .ee_rsp(ee_rsp), .al_valid(al_valid),
    .al_bits(al_bits), .link_down(link_down), .msi_addr_hi(msi_addr_hi),
    .msi_data(msi_data), .ltssm_role_change_en(role_en),
    .downstream_role_select(dn_role), .hot_reset_fwd(hr_fwd), .irq(irq));
  vmc_ee_model u_vmc_ee_model (.clk_sys(clk_sys), .rstn(rstn), .lat(lat),
    .ee_req(ee_req), .ee_rsp(ee_rsp));

  always #25 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_sys);
  endtask : wr

  // expected read data is queued for the monitor below
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    exp_q.push_back(e);
    nm_q.push_back(nm);
    @(posedge clk_sys);
  endtask : rd

  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  task automatic wait_done();
    for (int i = 0; i < 40 && ee_req.req !== 1'b0; i++) @(posedge clk_sys);
  endtask : wait_done

  task automatic do_reset(input logic u);
    rstn <= 1'b0;
    up <= u;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask : do_reset

  always @(posedge clk_sys) begin
    cyc++;
    if (rd_d) chk(rdata, exp_q.pop_front(), nm_q.pop_front());
    rd_d <= bus.rd;
    if (cyc > 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  initial begin
    do_reset(1'b0);
    rd(OFS_MSI_UPPER, 32'h0, "msi_hi_rst");
    rd(OFS_MSI_DATA, 32'h0, "msi_data_rst");
    rd(OFS_MSI_CTRL, 32'h00800000, "msi_ctrl");
    rd(OFS_VEND, 32'h0034B009, "vend_hdr");
    rd(OFS_LTC, 32'h04001060, "ltc_rst");
    rd(OFS_PD_CTRL, 32'h0, "pd_hidden");
    rd(8'h70, 32'h0, "unmapped");
    lfsr = rnd(lfsr);
    d = lfsr;
    wr(OFS_MSI_UPPER, d);
    wr(OFS_MSI_DATA, ~d);
    rd(OFS_MSI_UPPER, d, "msi_hi");
    rd(OFS_MSI_DATA, {16'h0, ~d[15:0]}, "msi_data");
    idle(1);
    chk(msi_addr_hi, d, "msi_addr_hi");
    chk({16'h0, msi_data}, {16'h0, ~d[15:0]}, "msi_data_out");
    $display("test msi done");
    wr(OFS_LTC, 32'h0000000A);
    idle(2);
    chk(dn_role, 1'b1, "role_dn");
    wr(OFS_LTC, 32'h00000000);
    idle(2);
    chk(dn_role, 1'b1, "role_frozen");
    chk(role_en, 1'b0, "role_en");
    wr(OFS_LTC, 32'h00000002);
    idle(2);
    chk(dn_role, 1'b0, "role_up");
    link_down <= 1'b1;
    al_bits <= 2'h3;
    al_valid <= 1'b1;
    @(posedge clk_sys);
    al_valid <= 1'b0;
    rd(OFS_LTC, 32'h00006002, "ltc_autoload");
    idle(2);
    chk(hr_fwd, 1'b0, "hot_fwd_dn");
    chk(irq, 1'b0, "irq_masked");
    wr(OFS_IRQ_MASK, 32'h4);
    idle(2);
    chk(irq, 1'b1, "irq_set");
    rd(OFS_IRQ_STAT, 32'h4, "irq_stat");
    idle(2);
    chk(irq, 1'b0, "irq_clear");
    $display("test downstream done");
    do_reset(1'b1);
    rd(OFS_PD_CTRL, 32'h00006403, "pd_hdr");
    rd(OFS_PD_DATA, 32'h0, "pd_data_rst");
    rd(OFS_MSI_UPPER, 32'h0, "msi_hidden");
    idle(1);
    chk(hr_fwd, 1'b1, "hot_fwd");
    wr(OFS_LTC, 32'h04001064);
    idle(1);
    chk(hr_fwd, 1'b0, "hot_block");
    foreach (adr[i]) begin
      lfsr = rnd(lfsr);
      d = lfsr;
      av = {8'h00, adr[i], 18'h0};
      lat <= (i == 0) ? 4'h0 : 4'h6;
      wr(OFS_PD_DATA, d);
      wr(OFS_PD_CTRL, 32'hC0000000 | av);
      rd(OFS_PD_CTRL, 32'hC0006403 | av, "flag_wr_busy");
      idle(1);
      wait_done();
      rd(OFS_PD_CTRL, 32'h40006403 | av, "flag_wr_end");
      wr(OFS_PD_DATA, ~d);
      wr(OFS_PD_CTRL, av);
      rd(OFS_PD_CTRL, 32'h00006403 | av, "flag_rd_busy");
      idle(1);
      wait_done();
      rd(OFS_PD_CTRL, 32'h80006403 | av, "flag_rd_end");
      rd(OFS_PD_DATA, d, "pd_data_rd");
    end
    wr(OFS_PD_CTRL, 32'h80000000 | av);
    idle(2);
    chk(ee_req.req, 1'b0, "refused_req");
    rd(OFS_PD_CTRL, 32'h80006403 | av, "refused_flag");
    rd(OFS_IRQ_STAT, 32'h3, "irq_stat_up");
    // two more edges so the monitor compares this read before the verdict
    idle(2);
    $display("test table done");
    finish_test();
  end
endmodule : test_vmc_regs

bind vmc_regs vmc_regs_props u_vmc_regs_props (.clk_sys(clk_sys), .rstn(rstn),
  .is_upstream(is_upstream), .bus(bus), .rdata(rdata), .ee_req(ee_req), .ee_rsp(ee_rsp),
  .link_down(link_down), .ltssm_role_change_en(ltssm_role_change_en),
  .downstream_role_select(downstream_role_select), .hot_reset_fwd(hot_reset_fwd));

// [vmc_ee_model.sv]
// vmc_ee_model: EEPROM table side, 64 words, done after lat cycles.
// assumes: request held until the cycle after done.
`timescale 1ns/10ps

module vmc_ee_model (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic [3:0] lat, // wait cycles before done
  input wire vmc_pkg::vmc_ee_req_s ee_req, // access request
  output vmc_pkg::vmc_ee_rsp_s ee_rsp // completion
);
  import vmc_pkg::*;
  logic [DW-1:0] mem [64];
  logic [3:0] cnt_reg;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      ee_rsp <= '0;
    end else begin
      ee_rsp.done <= 1'b0;
      // data outside done is not held, so stale values cannot pass
      ee_rsp.rdata <= ~ee_rsp.rdata;
      if (ee_req.req && !ee_rsp.done) begin
        if (cnt_reg == lat) begin
          cnt_reg <= 4'h0;
          ee_rsp.done <= 1'b1;
          if (ee_req.write) mem[ee_req.addr] <= ee_req.wdata;
          else ee_rsp.rdata <= mem[ee_req.addr];
        end else cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : vmc_ee_model

// [vmc_pkg.sv]
// vmc_pkg: offsets, field positions, reset values and types for the
// capability register bank.
// assumes: one 20 MHz clock, byte addresses on an 8-bit config offset.
package vmc_pkg;

  localparam int AW = 8;
  localparam int DW = 32;

  // register offsets
  localparam logic [AW-1:0] OFS_MSI_CTRL = 8'h4C;
  localparam logic [AW-1:0] OFS_MSI_UPPER = 8'h54;
  localparam logic [AW-1:0] OFS_MSI_DATA = 8'h58;
  localparam logic [AW-1:0] OFS_PD_CTRL = 8'h5C;
  localparam logic [AW-1:0] OFS_PD_DATA = 8'h60;
  localparam logic [AW-1:0] OFS_VEND = 8'h64;
  localparam logic [AW-1:0] OFS_LTC = 8'h68;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h80;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h84;

  // interrupt message fields
  localparam int MSI_64_BIT = 23;
  localparam logic MSI_64_CAP = 1'h1;
  localparam int MSI_DATA_W = 16;
  localparam logic [DW-1:0] MSI_UPPER_RST = 32'h00000000;
  localparam logic [MSI_DATA_W-1:0] MSI_DATA_RST = 16'h0000;

  // product data capability fields
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT = 8'h64;
  localparam int PD_ADDR_LSB = 18;
  localparam int PD_ADDR_W = 6;
  localparam int PD_WE_BIT = 30;
  localparam int PD_OP_BIT = 31;
  localparam logic [PD_ADDR_W-1:0] PD_ADDR_RST = 6'h00;
  localparam logic [DW-1:0] PD_DATA_RST = 32'h00000000;

  // vendor-specific capability fields
  localparam logic [7:0] VEND_ID = 8'h09;
  localparam logic [7:0] VEND_NEXT = 8'hB0;
  localparam logic [15:0] VEND_LEN = 16'h0034;

  // link test control fields
  localparam logic [DW-1:0] LTC_RST = 32'h04001060;
  localparam int LTC_ROLE_CHG = 1;
  localparam int LTC_NO_HOTRST = 2;
  localparam int LTC_DN_ROLE = 3;
  localparam int LTC_AL_LSB = 13;
  localparam int LTC_AL_W = 2;

  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  localparam int IRQ_AUTOLOAD = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } vmc_bus_s;

  typedef struct packed {
    logic req;
    logic write;
    logic [PD_ADDR_W-1:0] addr;
    logic [DW-1:0] wdata;
  } vmc_ee_req_s;

  typedef struct packed {
    logic done;
    logic [DW-1:0] rdata;
  } vmc_ee_rsp_s;

  typedef enum logic {ST_IDLE, ST_BUSY} vmc_state_e;

endpackage : vmc_pkg

// [vmc_regs.sv]
// vmc_regs: interrupt message upper address and data, product data
// capability with its EEPROM table access, vendor capability header and
// link test control word, plus a small interrupt status/mask pair.
// assumes: bus, EEPROM controller, strap and link status on clk_sys.
//
// Summary of operation
// - upper address used only with 64-bit capability
// - control bit 23 reports 64-bit capable, one
// - product data header identifier reads 03h
// - product data next pointer reads 64h
// - six-bit DWORD address at 23:18, resets zero
// - write-enable bit 30 gates table writes
// - flag zero reads table, sets when done
// - flag one writes table, clears when done
// - data word returns last fetched entry
// - data word write supplies table write data
// - vendor header identifier reads 09h
// - vendor next pointer reads B0h
// - vendor length field at 31:16 is 34h
// - bit 1 allows link role change
// - bit 2 blocks hot reset propagation downstream
// - bit 3 picks downstream or upstream role
// - EEPROM autoload replaces bits 14:13
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps

module vmc_regs (
  input wire logic clk_sys, // system clock, 20 MHz
  input wire logic rstn, // async reset, active low
  input wire logic is_upstream, // port is the upstream port
  input wire vmc_pkg::vmc_bus_s bus, // register request
  output logic [vmc_pkg::DW-1:0] rdata, // read data, cycle after read
  output vmc_pkg::vmc_ee_req_s ee_req, // table access to EEPROM side
  input wire vmc_pkg::vmc_ee_rsp_s ee_rsp, // table access completion
  input wire logic al_valid, // autoload pulse for test bits
  input wire logic [vmc_pkg::LTC_AL_W-1:0] al_bits, // autoload value
  input wire logic link_down, // upstream link went down
  output logic [vmc_pkg::DW-1:0] msi_addr_hi, // upper interrupt address
  output logic [vmc_pkg::MSI_DATA_W-1:0] msi_data, // interrupt data
  output logic ltssm_role_change_en, // role change allowed
  output logic downstream_role_select, // role is downstream port
  output logic hot_reset_fwd, // propagate hot reset downstream
  output logic irq // level interrupt
);
  import vmc_pkg::*;

  logic [DW-1:0] msi_upper_reg;
  logic [MSI_DATA_W-1:0] msi_data_reg;
  logic [PD_ADDR_W-1:0] pd_addr_reg;
  logic pd_we_reg;
  logic pd_op_reg;
  logic [DW-1:0] pd_data_reg;
  logic [DW-1:0] ltc_reg;
  logic role_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;
  vmc_state_e state_reg;
  logic ee_req_reg;
  logic ee_write_reg;
  logic [PD_ADDR_W-1:0] ee_addr_reg;
  logic [DW-1:0] ee_wdata_reg;

  logic wr_msi_upper;
  logic wr_msi_data;
  logic wr_pd_ctrl;
  logic wr_pd_data;
  logic wr_ltc;
  logic wr_irq_mask;
  logic rd_irq_stat;
  logic op_write;
  logic op_allowed;
  logic op_start;
  logic op_refused;
  logic op_done;
  logic [IRQ_W-1:0] irq_event;

  // write decode; port role hides the other port's registers
  assign wr_msi_upper = bus.wr && !is_upstream && bus.addr == OFS_MSI_UPPER;
  assign wr_msi_data = bus.wr && !is_upstream && bus.addr == OFS_MSI_DATA;
  assign wr_pd_ctrl = bus.wr && is_upstream && bus.addr == OFS_PD_CTRL;
  assign wr_pd_data = bus.wr && is_upstream && bus.addr == OFS_PD_DATA;
  assign wr_ltc = bus.wr && bus.addr == OFS_LTC;
  assign wr_irq_mask = bus.wr && bus.addr == OFS_IRQ_MASK;
  assign rd_irq_stat = bus.rd && bus.addr == OFS_IRQ_STAT;

  // table access start: control writes while busy are dropped
  assign op_write = bus.wdata[PD_OP_BIT];
  assign op_allowed = !op_write || bus.wdata[PD_WE_BIT];
  assign op_start = wr_pd_ctrl && state_reg == ST_IDLE && op_allowed;
  assign op_refused = wr_pd_ctrl && state_reg == ST_IDLE && !op_allowed;
  assign op_done = state_reg == ST_BUSY && ee_rsp.done;

  // interrupt message registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      msi_upper_reg <= MSI_UPPER_RST;
    end else if (wr_msi_upper) begin
      msi_upper_reg <= bus.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      msi_data_reg <= MSI_DATA_RST;
    end else if (wr_msi_data) begin
      msi_data_reg <= bus.wdata[MSI_DATA_W-1:0];
    end
  end

  // the upper half only reaches the message write on a 64-bit capability
  assign msi_addr_hi = MSI_64_CAP ? msi_upper_reg : '0;
  assign msi_data = msi_data_reg;

  // product data address and write enable, frozen during an access
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pd_addr_reg <= PD_ADDR_RST;
      pd_we_reg <= 1'h0;
    end else if (wr_pd_ctrl && state_reg == ST_IDLE) begin
      pd_addr_reg <= bus.wdata[PD_ADDR_LSB +: PD_ADDR_W];
      pd_we_reg <= bus.wdata[PD_WE_BIT];
    end
  end

  // operation flag: holds the written sense, flips on completion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pd_op_reg <= 1'h0;
    end else if (op_start) begin
      pd_op_reg <= op_write;
    end else if (op_done) begin
      pd_op_reg <= !ee_write_reg;
    end
  end

  // data word: fetched value wins over a same-cycle software write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pd_data_reg <= PD_DATA_RST;
    end else if (op_done && !ee_write_reg) begin
      pd_data_reg <= ee_rsp.rdata;
    end else if (wr_pd_data) begin
      pd_data_reg <= bus.wdata;
    end
  end

  // table access sequencer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (op_start) begin
            state_reg <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (ee_rsp.done) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // request to the EEPROM side, held until it reports done
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ee_req_reg <= 1'h0;
      ee_write_reg <= 1'h0;
      ee_addr_reg <= PD_ADDR_RST;
      ee_wdata_reg <= PD_DATA_RST;
    end else if (op_start) begin
      ee_req_reg <= 1'h1;
      ee_write_reg <= op_write;
      ee_addr_reg <= bus.wdata[PD_ADDR_LSB +: PD_ADDR_W];
      ee_wdata_reg <= pd_data_reg;
    end else if (op_done) begin
      ee_req_reg <= 1'h0;
    end
  end

  assign ee_req.req = ee_req_reg;
  assign ee_req.write = ee_write_reg;
  assign ee_req.addr = ee_addr_reg;
  assign ee_req.wdata = ee_wdata_reg;

  // link test control: autoload of bits 14:13 wins over software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ltc_reg <= LTC_RST;
    end else begin
      if (wr_ltc) begin
        ltc_reg <= bus.wdata;
      end
      if (al_valid) begin
        ltc_reg[LTC_AL_LSB +: LTC_AL_W] <= al_bits;
      end
    end
  end

  // role follows the select bit only while changes are allowed
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      role_reg <= LTC_RST[LTC_DN_ROLE];
    end else if (ltc_reg[LTC_ROLE_CHG]) begin
      role_reg <= ltc_reg[LTC_DN_ROLE];
    end
  end

  assign ltssm_role_change_en = ltc_reg[LTC_ROLE_CHG];
  assign downstream_role_select = role_reg;

  // hot reset goes down only from the upstream port, unless blocked
  assign hot_reset_fwd = is_upstream && link_down && !ltc_reg[LTC_NO_HOTRST];

  // interrupt events
  assign irq_event[IRQ_DONE] = op_done;
  assign irq_event[IRQ_REFUSED] = op_refused;
  assign irq_event[IRQ_AUTOLOAD] = al_valid;

  // sticky status, cleared by reading it; a new event wins the clear
  for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        irq_stat_reg[i] <= 1'h0;
      end else if (irq_event[i]) begin
        irq_stat_reg[i] <= 1'h1;
      end else if (rd_irq_stat) begin
        irq_stat_reg[i] <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= bus.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // read mux; absent and reserved fields read as zero
  always_comb begin
    rdata_next = '0;
    unique case (bus.addr)
      OFS_MSI_CTRL: begin
        if (!is_upstream) begin
          rdata_next[MSI_64_BIT] = MSI_64_CAP;
        end
      end
      OFS_MSI_UPPER: begin
        if (!is_upstream) begin
          rdata_next = msi_upper_reg;
        end
      end
      OFS_MSI_DATA: begin
        if (!is_upstream) begin
          rdata_next[MSI_DATA_W-1:0] = msi_data_reg;
        end
      end
      OFS_PD_CTRL: begin
        if (is_upstream) begin
          rdata_next[7:0] = PD_CAP_ID;
          rdata_next[15:8] = PD_NEXT;
          rdata_next[PD_ADDR_LSB +: PD_ADDR_W] = pd_addr_reg;
          rdata_next[PD_WE_BIT] = pd_we_reg;
          rdata_next[PD_OP_BIT] = pd_op_reg;
        end
      end
      OFS_PD_DATA: begin
        if (is_upstream) begin
          rdata_next = pd_data_reg;
        end
      end
      OFS_VEND: begin
        rdata_next[7:0] = VEND_ID;
        rdata_next[15:8] = VEND_NEXT;
        rdata_next[31:16] = VEND_LEN;
      end
      OFS_LTC: begin
        rdata_next = ltc_reg;
      end
      OFS_IRQ_STAT: begin
        rdata_next[IRQ_W-1:0] = irq_stat_reg;
      end
      OFS_IRQ_MASK: begin
        rdata_next[IRQ_W-1:0] = irq_mask_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else if (bus.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata = rdata_reg;

endmodule : vmc_regs

// [vmc_regs_props.sv]
// vmc_regs_props: port-level checks of the capability register bank.
// assumes: bound to vmc_regs, one clock, async active-low reset.
`timescale 1ns/10ps

module vmc_regs_props (
  input wire logic clk_sys, // clock
  input wire logic rstn, // reset, active low
  input wire logic is_upstream, // port role
  input wire vmc_pkg::vmc_bus_s bus, // register request
  input wire logic [vmc_pkg::DW-1:0] rdata, // read data
  input wire vmc_pkg::vmc_ee_req_s ee_req, // table request
  input wire vmc_pkg::vmc_ee_rsp_s ee_rsp, // table completion
  input wire logic link_down, // link down
  input wire logic ltssm_role_change_en, // role change allowed
  input wire logic downstream_role_select, // role
  input wire logic hot_reset_fwd // hot reset forward
);
  import vmc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic pd_wr;
  assign pd_wr = bus.wr && bus.addr == OFS_PD_CTRL && is_upstream && !ee_req.req;
  vend_hdr_a: assert property (bus.rd && bus.addr == OFS_VEND |=>
    rdata == 32'h0034B009) else $error("vendor header wrong");
  pd_hdr_a: assert property (bus.rd && bus.addr == OFS_PD_CTRL && is_upstream |=>
    rdata[15:0] == 16'h6403) else $error("product data header wrong");
  msi_cap_a: assert property (bus.rd && bus.addr == OFS_MSI_CTRL && !is_upstream |=>
    rdata[23]) else $error("64-bit capable bit low");
  pd_start_a: assert property (pd_wr |=>
    ee_req.req == ($past(bus.wdata[30]) || !$past(bus.wdata[31])))
    else $error("table access start wrong");
  pd_addr_a: assert property (pd_wr |=> !ee_req.req ||
    (ee_req.addr == $past(bus.wdata[23:18]) && ee_req.write == $past(bus.wdata[31])))
    else $error("table access address or kind wrong");
  ee_hold_a: assert property (ee_req.req && !ee_rsp.done |=>
    ee_req.req && $stable(ee_req)) else $error("table request not held");
  ee_end_a: assert property (ee_req.req && ee_rsp.done |=> !ee_req.req)
    else $error("table request not ended");
  hot_rst_a: assert property (hot_reset_fwd |-> is_upstream && link_down)
    else $error("hot reset forwarded wrongly");
  role_frz_a: assert property (!ltssm_role_change_en |=> $stable(downstream_role_select))
    else $error("role changed while locked");
  cover property (pd_wr && bus.wdata[31]);
  cover property (ee_req.req && ee_rsp.done);
  cover property (hot_reset_fwd);
endmodule : vmc_regs_props
